// [common/vic_pkg.sv]
// Constants and types for the vectored interrupt controller
// Contract
// - Priority bits: timer0 bit1, timer1 bit3, serial bit4, internal bit5; 1 is high.
// - Kernel enable at bit 0 of its register; bits 7..1 read zero.
// - Kernel priority at bit 0 of its register; other bits reserved.
// - Timer run bits: timer0 bit4, timer1 bit6; bits 3..0 reserved.
// - Overflow flags set on overflow, cleared when the routine is entered.
// - All extra sources OR into one active-low level interrupt line.
// - Up to 32 vectors; processor reads the vector and dispatches.
// - Vector and queue cleared by reset, or bus reset with function reset connected.
// - Any write to the vector register drops the vector and shows the next.
// - Vector bit 0 is always zero.
// - Vector reads zero when nothing is pending.
// - Read-only vector: source index in bits 3..1, group in bits 7..4.
// - Higher group served first; within a group first come first served.
// - Group 1: input endpoint 1..4 ack at 10..16, nack at 18..1e.
// - Group 2: output endpoint 1..4 ack at 20..26, nack at 28..2e.
// - Group 3: setup overwrite, setup, resume, suspend, bus reset at 30..38.
// - Group 4: endpoint-0 ack/nack 40..46, disk 48, wake clock 4a.
// - Vectors 4c..4e and groups 5..15 are never produced.
// - Internal interrupt passes only with its enable and the global enable set.
package vic_pkg;
   localparam logic [7:0] ADDR_TIMER_CTRL  = 8'h88;
   localparam logic [7:0] ADDR_IRQ_EN      = 8'ha8;
   localparam logic [7:0] ADDR_PRIO        = 8'hb8;
   localparam logic [7:0] ADDR_KERNEL_EN   = 8'he8;
   localparam logic [7:0] ADDR_VECTOR      = 8'hf7;
   localparam logic [7:0] ADDR_KERNEL_PRIO = 8'hf8;
   localparam int BIT_T0    = 1;
   localparam int BIT_T1    = 3;
   localparam int BIT_SER   = 4;
   localparam int BIT_INT   = 5;
   localparam int BIT_GLOB  = 7;
   localparam int BIT_KERN  = 0;
   localparam int BIT_T0RUN = 4;
   localparam int BIT_T0OVF = 5;
   localparam int BIT_T1RUN = 6;
   localparam int BIT_T1OVF = 7;
   localparam logic [7:0] MASK_TIMER  = 8'hf0;
   localparam logic [7:0] MASK_IRQ_EN = 8'hba;
   localparam logic [7:0] MASK_PRIO   = 8'h3a;
   localparam logic [7:0] MASK_KERNEL = 8'h01;
   localparam logic [7:0] REG_RESET   = 8'h00;
   localparam int NUM_GROUPS = 4;
   localparam int GROUP_SRCS = 8;
   localparam logic [7:0] USED_G1 = 8'hff;
   localparam logic [7:0] USED_G2 = 8'hff;
   localparam logic [7:0] USED_G3 = 8'h1f;
   localparam logic [7:0] USED_G4 = 8'h3f;

   typedef enum logic [2:0] {
      SRC_NONE, SRC_TIMER0, SRC_TIMER1, SRC_SERIAL, SRC_INTERNAL, SRC_KERNEL
   } vic_src_t;

   typedef struct packed {
      logic [7:0]                      arrived;
      logic [7:0]                      queued;
      logic [GROUP_SRCS-1:0][2:0]      slot;
      logic [2:0]                      rdPtr;
      logic [2:0]                      wrPtr;
      logic [3:0]                      count;
   } vic_queue_t;

   typedef struct packed {
      logic [7:0] timerCtrl;
      logic [7:0] irqEn;
      logic [7:0] prio;
      logic [7:0] kernelEn;
      logic [7:0] kernelPrio;
      logic [7:0] rdData;
      logic       mergedN;
      logic       irqReq;
      logic       irqHigh;
      vic_src_t   irqSrc;
   } vic_top_t;

   localparam vic_top_t TOP_RESET = '{timerCtrl: REG_RESET, irqEn: REG_RESET,
      prio: REG_RESET, kernelEn: REG_RESET, kernelPrio: REG_RESET,
      rdData: REG_RESET, mergedN: 1'b1, irqReq: 1'b0, irqHigh: 1'b0,
      irqSrc: SRC_NONE};
endpackage : vic_pkg

// [common/vic_grp_if.sv]
// Link between the top and one per-group vector queue
`timescale 1ns/100ps
interface vic_grp_if;
   logic [7:0] evt;
   logic       pop;
   logic       clr;
   logic [2:0] head;
   logic       notEmpty;
   modport queue (input evt, input pop, input clr, output head, output notEmpty);
   modport ctrl (output evt, output pop, output clr, input head, input notEmpty);
endinterface : vic_grp_if

// [hw/vic_vector_queue.sv]
// First-come first-served queue of pending sources for one vector group
`timescale 1ns/100ps
module vic_vector_queue #(
   parameter logic [7:0] USED = 8'hff
) (
   input  wire logic clk_sys,
   input  wire logic rst_n,
   vic_grp_if.queue  g
);
   import vic_pkg::*;

   vic_queue_t s;
   vic_queue_t n;
   logic [2:0] pick;
   logic       found;
   logic       popNow;
   logic [7:0] evtUsed;

   assign evtUsed    = g.evt & USED;
   assign g.head     = s.slot[s.rdPtr];
   assign g.notEmpty = (s.count != 4'h0);

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      n      = s;
      pick   = 3'h0;
      found  = 1'b0;
      popNow = g.pop && (s.count != 4'h0);
      if (popNow) begin
         n.queued[s.slot[s.rdPtr]] = 1'b0;
         n.rdPtr = s.rdPtr + 3'h1;
      end
      // Simultaneous arrivals enter one per cycle, lowest index first
      for (int i = GROUP_SRCS - 1; i >= 0; i--) begin
         if (s.arrived[i]) begin
            pick  = 3'(i);
            found = 1'b1;
         end
      end
      if (found) begin
         n.arrived[pick] = 1'b0;
         n.queued[pick]  = 1'b1;
         n.slot[s.wrPtr] = pick;
         n.wrPtr         = s.wrPtr + 3'h1;
      end
      n.count = s.count + {3'h0, found} - {3'h0, popNow};
      // A source popped this cycle may arrive again at once
      n.arrived = n.arrived | (evtUsed & ~n.queued);
      if (g.clr) begin
         n = '0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_firstArrival;
      (s.count == 4'h0 && s.arrived == 8'h0 && evtUsed != 8'h0 && !g.clr) ##1 !g.clr;
   endsequence
   property p_arrive;
      @(posedge clk_sys) disable iff (!rst_n) s_firstArrival |=> g.notEmpty;
   endproperty
   a_arrive: assert property (p_arrive) else $error("queued event not shown");
   property p_lastPop;
      @(posedge clk_sys) disable iff (!rst_n)
         (s.count == 4'h1 && g.pop && s.arrived == 8'h0 && evtUsed == 8'h0) |=> !g.notEmpty;
   endproperty
   a_lastPop: assert property (p_lastPop) else $error("pop left queue busy");
endmodule : vic_vector_queue

// [hw/vic_top.sv]
// Interrupt enable, priority, timer flag and vectored internal interrupt logic
`timescale 1ns/100ps
module vic_top (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic [7:0]       sfrAddr,
   input  wire logic             sfrWrite,
   input  wire logic [7:0]       sfrWrData,
   input  wire logic             sfrRead,
   output logic [7:0]            sfrRdData,
   input  wire logic [7:0]       grp1Event,
   input  wire logic [7:0]       grp2Event,
   input  wire logic [4:0]       grp3Event,
   input  wire logic [5:0]       grp4Event,
   input  wire logic             usbBusReset,
   input  wire logic             functionResetConnect,
   input  wire logic             timer0Overflow,
   input  wire logic             timer1Overflow,
   input  wire logic             serialIrq,
   input  wire logic             kernelIrq,
   input  wire logic             irqTaken,
   input  wire vic_pkg::vic_src_t irqTakenSrc,
   output logic                  timer0Run,
   output logic                  timer1Run,
   output logic                  mergedIrqN,
   output logic                  irqReq,
   output logic                  irqHigh,
   output vic_pkg::vic_src_t     irqSrc
);
   import vic_pkg::*;

   vic_top_t s;
   vic_top_t n;

   logic                        funcRst;
   logic                        vecPop;
   logic [NUM_GROUPS-1:0][7:0]  grpEvt;
   logic [NUM_GROUPS-1:0]       grpNe;
   logic [NUM_GROUPS-1:0][2:0]  grpHead;
   logic [1:0]                  topGrp;
   logic [7:0]                  vector;
   logic [4:0]                  req;
   logic [4:0]                  hi;
   logic                        hiAny;
   logic                        anyPend;

   ////////////////////////////////////////////////////////////////////////////
   // Register read mux; reserved bits are never stored, so they read zero
   function automatic logic [7:0] readReg(
      input logic [7:0] a,
      input vic_top_t   r,
      input logic [7:0] v
   );
      logic [7:0] d;
      d = 8'h00;
      if (a == ADDR_TIMER_CTRL) begin
         d = r.timerCtrl;
      end else if (a == ADDR_IRQ_EN) begin
         d = r.irqEn;
      end else if (a == ADDR_PRIO) begin
         d = r.prio;
      end else if (a == ADDR_KERNEL_EN) begin
         d = r.kernelEn;
      end else if (a == ADDR_VECTOR) begin
         d = v;
      end else if (a == ADDR_KERNEL_PRIO) begin
         d = r.kernelPrio;
      end
      return d;
   endfunction : readReg

   function automatic vic_src_t srcOf(input int i);
      return vic_src_t'(3'(i + 1));
   endfunction : srcOf

   ////////////////////////////////////////////////////////////////////////////
   // Vector groups: index i of group g is vector {g, i, 0}
   assign funcRst = usbBusReset && functionResetConnect;
   assign vecPop  = sfrWrite && (sfrAddr == ADDR_VECTOR);

   assign grpEvt[0] = grp1Event;
   assign grpEvt[1] = grp2Event;
   assign grpEvt[2] = {3'h0, grp3Event};
   assign grpEvt[3] = {2'h0, grp4Event};

   genvar gi;
   generate
      for (gi = 0; gi < NUM_GROUPS; gi++) begin : g_grp
         localparam logic [7:0] USED_MASK = (gi == 0) ? USED_G1 :
                                            (gi == 1) ? USED_G2 :
                                            (gi == 2) ? USED_G3 : USED_G4;
         vic_grp_if link ();
         assign link.evt    = grpEvt[gi];
         assign link.pop    = vecPop && (topGrp == 2'(gi));
         assign link.clr    = funcRst;
         assign grpNe[gi]   = link.notEmpty;
         assign grpHead[gi] = link.head;
         vic_vector_queue #(
            .USED (USED_MASK)
         ) u_queue (
            .clk_sys (clk_sys),
            .rst_n   (rst_n),
            .g       (link)
         );
      end
   endgenerate

   // Highest non-empty group wins; vector zero only when all four queues are empty
   always_comb begin
      topGrp = 2'h0;
      vector = 8'h00;
      for (int i = 0; i < NUM_GROUPS; i++) begin
         if (grpNe[i]) begin
            topGrp = 2'(i);
            vector = {4'(i + 1), grpHead[i], 1'b0};
         end
      end
   end

   assign anyPend = (grpNe != 4'h0);

   ////////////////////////////////////////////////////////////////////////////
   // Request selection for the processor core
   always_comb begin
      req[0] = s.timerCtrl[BIT_T0OVF] && s.irqEn[BIT_T0];
      req[1] = s.timerCtrl[BIT_T1OVF] && s.irqEn[BIT_T1];
      req[2] = serialIrq && s.irqEn[BIT_SER];
      req[3] = !s.mergedN && s.irqEn[BIT_INT];
      req[4] = kernelIrq && s.kernelEn[BIT_KERN];
      if (!s.irqEn[BIT_GLOB]) begin
         req = 5'h00;
      end
      hi[0] = s.prio[BIT_T0];
      hi[1] = s.prio[BIT_T1];
      hi[2] = s.prio[BIT_SER];
      hi[3] = s.prio[BIT_INT];
      hi[4] = s.kernelPrio[BIT_KERN];
      hiAny = |(req & hi);
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      n = s;
      if (sfrWrite) begin
         if (sfrAddr == ADDR_TIMER_CTRL) begin
            n.timerCtrl = sfrWrData & MASK_TIMER;
         end else if (sfrAddr == ADDR_IRQ_EN) begin
            n.irqEn = sfrWrData & MASK_IRQ_EN;
         end else if (sfrAddr == ADDR_PRIO) begin
            n.prio = sfrWrData & MASK_PRIO;
         end else if (sfrAddr == ADDR_KERNEL_EN) begin
            n.kernelEn = sfrWrData & MASK_KERNEL;
         end else if (sfrAddr == ADDR_KERNEL_PRIO) begin
            n.kernelPrio = sfrWrData & MASK_KERNEL;
         end
      end
      // Entering the routine clears the flag; an overflow in that cycle wins
      if (irqTaken && irqTakenSrc == SRC_TIMER0) begin
         n.timerCtrl[BIT_T0OVF] = 1'b0;
      end
      if (irqTaken && irqTakenSrc == SRC_TIMER1) begin
         n.timerCtrl[BIT_T1OVF] = 1'b0;
      end
      if (timer0Overflow) begin
         n.timerCtrl[BIT_T0OVF] = 1'b1;
      end
      if (timer1Overflow) begin
         n.timerCtrl[BIT_T1OVF] = 1'b1;
      end
      n.mergedN = !anyPend;
      if (sfrRead) begin
         n.rdData = readReg(sfrAddr, s, vector);
      end
      // Low requests first, then high ones overwrite
      n.irqReq  = |req;
      n.irqHigh = 1'b0;
      n.irqSrc  = SRC_NONE;
      for (int i = 4; i >= 0; i--) begin
         if (req[i] && !hi[i]) begin
            n.irqSrc = srcOf(i);
         end
      end
      for (int i = 4; i >= 0; i--) begin
         if (req[i] && hi[i]) begin
            n.irqSrc  = srcOf(i);
            n.irqHigh = 1'b1;
         end
      end
      if (funcRst) begin
         n = TOP_RESET;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s <= TOP_RESET;
      end else begin
         s <= n;
      end
   end

   assign sfrRdData  = s.rdData;
   assign timer0Run  = s.timerCtrl[BIT_T0RUN];
   assign timer1Run  = s.timerCtrl[BIT_T1RUN];
   assign mergedIrqN = s.mergedN;
   assign irqReq     = s.irqReq;
   assign irqHigh    = s.irqHigh;
   assign irqSrc     = s.irqSrc;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence s_vecRead;
      sfrRead && sfrAddr == ADDR_VECTOR && !funcRst;
   endsequence

   property p_vecBit0;
      s_vecRead |=> sfrRdData[0] == 1'b0;
   endproperty
   a_vecBit0: assert property (p_vecBit0) else $error("vector bit 0 set");

   property p_vecEmpty;
      s_vecRead and (grpNe == 4'h0) |=> sfrRdData == 8'h00;
   endproperty
   a_vecEmpty: assert property (p_vecEmpty) else $error("empty vector not zero");

   property p_vecTop;
      s_vecRead and grpNe[3] |=> sfrRdData[7:4] == 4'h4;
   endproperty
   a_vecTop: assert property (p_vecTop) else $error("highest group not shown");

   property p_vecRange;
      s_vecRead |=> sfrRdData < 8'h4c;
   endproperty
   a_vecRange: assert property (p_vecRange) else $error("unused vector read");

   property p_level;
      !funcRst |=> mergedIrqN == ($past(grpNe) == 4'h0);
   endproperty
   a_level: assert property (p_level) else $error("internal line wrong");

   property p_funcClear;
      funcRst |=> (grpNe == 4'h0) && mergedIrqN && sfrRdData == 8'h00;
   endproperty
   a_funcClear: assert property (p_funcClear) else $error("bus reset no clear");

   property p_ovfSet;
      timer0Overflow && !funcRst |=> s.timerCtrl[BIT_T0OVF];
   endproperty
   a_ovfSet: assert property (p_ovfSet) else $error("overflow flag not set");

   property p_runWrite;
      sfrWrite && sfrAddr == ADDR_TIMER_CTRL && !funcRst
         |=> timer1Run == $past(sfrWrData[BIT_T1RUN]) && s.timerCtrl[3:0] == 4'h0;
   endproperty
   a_runWrite: assert property (p_runWrite) else $error("run bit not stored");

   property p_gate;
      !s.irqEn[BIT_GLOB] && !funcRst |=> !irqReq;
   endproperty
   a_gate: assert property (p_gate) else $error("request with global off");

   property p_high;
      hiAny && !funcRst |=> irqReq && irqHigh;
   endproperty
   a_high: assert property (p_high) else $error("high request not first");

   property p_kernRsv;
      sfrRead && sfrAddr == ADDR_KERNEL_EN && !funcRst |=> sfrRdData[7:1] == 7'h00;
   endproperty
   a_kernRsv: assert property (p_kernRsv) else $error("reserved bits set");
endmodule : vic_top

// [test/vic_core_model.sv]
// Core-side model that enters the routine of the selected request
`timescale 1ns/100ps
module vic_core_model (
   input  wire logic              clk_sys,
   input  wire logic              active,
   input  wire logic              slow,
   input  wire logic              irqReq,
   input  wire vic_pkg::vic_src_t irqSrc,
   output logic                   irqTaken,
   output vic_pkg::vic_src_t      irqTakenSrc
);
   import vic_pkg::*;
   int         waitN   = 0;
   logic [2:0] idle    = 3'h0;
   logic       takeNow = 1'b0;
   initial begin
      irqTaken = 1'b0;
      irqTakenSrc = SRC_NONE;
      forever begin
         @(posedge clk_sys);
         #1;
         // Source code toggles while no routine is entered
         idle = idle + 3'h1;
         takeNow = 1'b0;
         if (active && irqReq) begin
            waitN++;
            if (waitN > (slow ? 5 : 0)) begin
               takeNow = 1'b1;
               // Flag clears a few cycles later; do not enter twice
               waitN = -3;
            end
         end else begin
            // Each new request waits the full delay again
            waitN = 0;
         end
         irqTaken = takeNow;
         irqTakenSrc = takeNow ? irqSrc : vic_src_t'(idle);
      end
   end
endmodule : vic_core_model

// [test/vic_top_tb.sv]
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/100ps
module vic_top_tb;
   import vic_pkg::*;
   logic        clk_sys, rst_n, sfrWrite, sfrRead, usbBusReset, functionResetConnect;
   logic        timer0Overflow, timer1Overflow, serialIrq, kernelIrq, irqTaken;
   logic        timer0Run, timer1Run, mergedIrqN, irqReq, irqHigh, active, slow;
   logic [7:0]  sfrAddr, sfrWrData, sfrRdData, grp1Event, grp2Event;
   logic [4:0]  grp3Event;
   logic [5:0]  grp4Event;
   vic_src_t    irqTakenSrc, irqSrc;
   int          mismatches = 0;
   int          numChecks = 0;
   int          cycles = 0;
   logic [7:0]  regs [7] = '{ADDR_TIMER_CTRL, ADDR_IRQ_EN, ADDR_PRIO, ADDR_KERNEL_EN,
                             ADDR_KERNEL_PRIO, ADDR_VECTOR, 8'h90};
   logic [7:0]  masks [7] = '{MASK_TIMER, MASK_IRQ_EN, MASK_PRIO, MASK_KERNEL, MASK_KERNEL,
                              8'h00, 8'h00};
   logic [7:0]  order [7] = '{8'h30, 8'h2e, 8'h22, 8'h26, 8'h1a, 8'h14, 8'h00};

   vic_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
      .sfrWrData(sfrWrData), .sfrRead(sfrRead), .sfrRdData(sfrRdData),
      .grp1Event(grp1Event), .grp2Event(grp2Event), .grp3Event(grp3Event),
      .grp4Event(grp4Event), .usbBusReset(usbBusReset),
      .functionResetConnect(functionResetConnect), .timer0Overflow(timer0Overflow),
      .timer1Overflow(timer1Overflow), .serialIrq(serialIrq), .kernelIrq(kernelIrq),
      .irqTaken(irqTaken), .irqTakenSrc(irqTakenSrc), .timer0Run(timer0Run),
      .timer1Run(timer1Run), .mergedIrqN(mergedIrqN), .irqReq(irqReq),
      .irqHigh(irqHigh), .irqSrc(irqSrc));

   vic_core_model core_u (.clk_sys(clk_sys), .active(active), .slow(slow),
      .irqReq(irqReq), .irqSrc(irqSrc), .irqTaken(irqTaken), .irqTakenSrc(irqTakenSrc));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         finish_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      if (mismatches == 0 && numChecks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      numChecks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      tick(1);
      sfrAddr = a;
      sfrWrData = d;
      sfrWrite = 1'b1;
      tick(1);
      sfrWrite = 1'b0;
      sfrWrData = ~d;
   endtask : wr

   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
      tick(1);
      sfrAddr = a;
      sfrRead = 1'b1;
      tick(1);
      sfrRead = 1'b0;
      check(sfrRdData, exp);
   endtask : rdChk

   // Event pulses: group 1 in bits 7..0, group 2 15..8, group 3 20..16, group 4 29..24
   task automatic ev(input logic [31:0] w);
      tick(1);
      {grp4Event, grp3Event, grp2Event, grp1Event} = {w[29:24], w[20:16], w[15:0]};
      tick(1);
      {grp4Event, grp3Event, grp2Event, grp1Event} = '0;
   endtask : ev

   task automatic busRst(input logic connect);
      tick(1);
      usbBusReset = 1'b1;
      functionResetConnect = connect;
      tick(1);
      usbBusReset = 1'b0;
      functionResetConnect = 1'b0;
      tick(2);
   endtask : busRst

   task automatic chkReq(input logic req, input logic high, input vic_src_t src);
      check({irqReq, irqHigh, 3'h0, irqSrc}, {req, high, 3'h0, src});
   endtask : chkReq

   function automatic logic [7:0] vecOf(input int g, input int i);
      return 8'(g * 16 + i * 2);
   endfunction : vecOf

   function automatic logic used(input int g, input int i);
      return g < 3 || (g == 3 && i < 5) || (g == 4 && i < 6);
   endfunction : used

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] d;
      {rst_n, sfrWrite, sfrRead, usbBusReset, functionResetConnect} = '0;
      {timer0Overflow, timer1Overflow, serialIrq, kernelIrq, active, slow} = '0;
      {sfrAddr, sfrWrData, grp1Event, grp2Event, grp3Event, grp4Event} = '0;
      void'($urandom(72));
      repeat (6) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      foreach (regs[k]) rdChk(regs[k], 8'h00);
      repeat (6) begin
         foreach (regs[k]) begin
            d = 8'($urandom);
            wr(regs[k], d);
            rdChk(regs[k], d & masks[k]);
            if (k == 0) check({6'h0, timer1Run, timer0Run}, {6'h0, d[6], d[4]});
         end
      end
      foreach (regs[k]) wr(regs[k], 8'h00);
      // Every source lands on its own vector and is popped by a write
      for (int g = 1; g <= 4; g++) begin
         for (int i = 0; i < 8; i++) begin
            if (used(g, i)) begin
               ev(32'h1 << ((g - 1) * 8 + i));
               tick(3);
               check({7'h0, mergedIrqN}, 8'h00);
               rdChk(ADDR_VECTOR, vecOf(g, i));
               wr(ADDR_VECTOR, 8'($urandom));
               tick(2);
               check({7'h0, mergedIrqN}, 8'h01);
               rdChk(ADDR_VECTOR, 8'h00);
            end
         end
      end
      // Group order, arrival order, lowest index first, repeat ignored
      ev(32'h0000_0020);
      ev(32'h0000_0004);
      ev(32'h0001_8000);
      ev(32'h0000_0a00);
      ev(32'h0000_0020);
      tick(6);
      foreach (order[k]) begin
         rdChk(ADDR_VECTOR, order[k]);
         wr(ADDR_VECTOR, 8'h00);
         tick(2);
      end
      // Bus reset clears only with the function reset connected
      ev(32'h1000_0000);
      wr(ADDR_IRQ_EN, 8'ha0);
      busRst(1'b0);
      rdChk(ADDR_VECTOR, 8'h48);
      busRst(1'b1);
      check({7'h0, mergedIrqN}, 8'h01);
      rdChk(ADDR_VECTOR, 8'h00);
      rdChk(ADDR_IRQ_EN, 8'h00);
      // Internal request needs its enable and the global enable
      ev(32'h2000_0000);
      wr(ADDR_IRQ_EN, 8'h20);
      tick(4);
      check({7'h0, irqReq}, 8'h00);
      wr(ADDR_IRQ_EN, 8'ha0);
      tick(2);
      chkReq(1'b1, 1'b0, SRC_INTERNAL);
      wr(ADDR_PRIO, 8'h20);
      tick(2);
      chkReq(1'b1, 1'b1, SRC_INTERNAL);
      wr(ADDR_VECTOR, 8'h00);
      tick(4);
      check({7'h0, irqReq}, 8'h00);
      // High level beats low level, then fixed order at one level
      wr(ADDR_IRQ_EN, 8'h92);
      wr(ADDR_PRIO, 8'h10);
      timer0Overflow = 1'b1;
      serialIrq = 1'b1;
      tick(1);
      timer0Overflow = 1'b0;
      tick(3);
      chkReq(1'b1, 1'b1, SRC_SERIAL);
      wr(ADDR_PRIO, 8'h02);
      tick(2);
      chkReq(1'b1, 1'b1, SRC_TIMER0);
      wr(ADDR_PRIO, 8'h00);
      tick(2);
      chkReq(1'b1, 1'b0, SRC_TIMER0);
      serialIrq = 1'b0;
      rdChk(ADDR_TIMER_CTRL, 8'h20);
      // Entering the routine clears the flag, slow and prompt core
      active = 1'b1;
      slow = 1'b1;
      tick(12);
      rdChk(ADDR_TIMER_CTRL, 8'h00);
      wr(ADDR_IRQ_EN, 8'h88);
      slow = 1'b0;
      timer1Overflow = 1'b1;
      tick(1);
      timer1Overflow = 1'b0;
      tick(6);
      rdChk(ADDR_TIMER_CTRL, 8'h00);
      active = 1'b0;
      // Kernel request with its own enable and priority
      wr(ADDR_IRQ_EN, 8'h80);
      wr(ADDR_KERNEL_EN, 8'hff);
      wr(ADDR_KERNEL_PRIO, 8'hff);
      kernelIrq = 1'b1;
      tick(3);
      chkReq(1'b1, 1'b1, SRC_KERNEL);
      wr(ADDR_KERNEL_EN, 8'h00);
      tick(2);
      check({7'h0, irqReq}, 8'h00);
      kernelIrq = 1'b0;
      finish_test();
   end
endmodule : vic_top_tb
